// ### timer_cfg.svh
// Constants for the dual timer/counter block
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH
`define TMR_IDX_RUN 8'h88
`define TMR_IDX_MODE 8'h89
`define TMR_IDX_TL0 8'h8A
`define TMR_IDX_TL1 8'h8B
`define TMR_IDX_TH0 8'h8C
`define TMR_IDX_TH1 8'h8D
`define TMR_IDX_STAT 8'h90
`define TMR_IDX_MASK 8'h91
`define TMR_ADDR_W 12
`define TMR_MODE_PRE13 2'h0
`define TMR_MODE_16 2'h1
`define TMR_MODE_RELOAD 2'h2
`define TMR_MODE_SPLIT 2'h3
`define TMR_PRE_MAX 5'h1F
`define TMR_BYTE_MAX 8'hFF
`define TMR_BYTE_ONE 8'h01
`define TMR_WORD_ONE 16'h0001
`define TMR_BYTE_RST 8'h00
`define TMR_WORD_RST 32'h0000_0000
`define TMR_RUN0_BIT 4
`define TMR_FLAG0_BIT 5
`define TMR_RUN1_BIT 6
`define TMR_FLAG1_BIT 7
`define TMR_ST_OVF0 0
`define TMR_ST_OVF1 1
`define TMR_CFG0_LSB 0
`define TMR_CFG1_LSB 4
`define TMR_TICK_DIV 12
`endif

// ### timer_pkg.sv
// Types shared by the dual timer/counter block
package timer_pkg;
   typedef struct packed {
      logic gate;
      logic src;
      logic [1:0] mode;
   } timer_cfg_s;
   typedef struct packed {
      logic wr_lo;
      logic wr_hi;
      logic [7:0] data;
   } byte_wr_s;
endpackage

// ### timer_unit.sv
// One timer/counter channel: mode logic and its two count bytes
`timescale 1ns/10ps
`include "timer_cfg.svh"
module timer_unit #(
   parameter bit SPLIT_OK = 1'b1
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Control
   input timer_pkg::timer_cfg_s cfg,
   input wire logic run,
   input wire logic run_aux,
   input wire logic gate_pin,
   input wire logic tick,
   input wire logic ext_fall,
   input timer_pkg::byte_wr_s wr,
   // Count state and carries
   output logic [7:0] low_q,
   output logic [7:0] high_q,
   output logic ovf_main,
   output logic ovf_aux
);
   import timer_pkg::*;

   logic en;
   logic inc;
   logic inc_aux;
   logic [7:0] lo_d;
   logic [7:0] hi_d;

   always_comb begin
      // [RULE7] gate with pin
      en = run & (~cfg.gate | gate_pin);
      // [RULE6] source select
      inc = en & (cfg.src ? ext_fall : tick);
      inc_aux = run_aux & tick;
      lo_d = low_q;
      hi_d = high_q;
      ovf_main = 1'b0;
      ovf_aux = 1'b0;
      unique case (cfg.mode)
         // [RULE1] prescaled 13-bit
         `TMR_MODE_PRE13: begin
            if (inc) begin
               lo_d[4:0] = low_q[4:0] + 5'h01;
               if (low_q[4:0] == `TMR_PRE_MAX) begin
                  hi_d = high_q + `TMR_BYTE_ONE;
                  ovf_main = (high_q == `TMR_BYTE_MAX);
               end
            end
         end
         // [RULE1] full 16-bit
         `TMR_MODE_16: begin
            if (inc) begin
               {hi_d, lo_d} = {high_q, low_q} + `TMR_WORD_ONE;
               ovf_main = &{high_q, low_q};
            end
         end
         // [RULE2] auto reload
         `TMR_MODE_RELOAD: begin
            if (inc) begin
               if (low_q == `TMR_BYTE_MAX) begin
                  lo_d = high_q;
                  ovf_main = 1'b1;
               end else begin
                  lo_d = low_q + `TMR_BYTE_ONE;
               end
            end
         end
         `TMR_MODE_SPLIT: begin
            // [RULE3] two 8-bit counters
            if (SPLIT_OK) begin
               if (inc) begin
                  lo_d = low_q + `TMR_BYTE_ONE;
                  ovf_main = (low_q == `TMR_BYTE_MAX);
               end
               if (inc_aux) begin
                  hi_d = high_q + `TMR_BYTE_ONE;
                  ovf_aux = (high_q == `TMR_BYTE_MAX);
               end
            end
            // [RULE4] timer 1 holds
         end
      endcase
      // Software write beats a count in the same cycle
      if (wr.wr_lo) begin
         lo_d = wr.data;
      end
      if (wr.wr_hi) begin
         hi_d = wr.data;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         low_q <= `TMR_BYTE_RST;
         high_q <= `TMR_BYTE_RST;
      end else begin
         low_q <= lo_d;
         high_q <= hi_d;
      end
   end
endmodule

// ### dual_timer.sv
// Dual timer/counter with APB register access and overflow interrupt
//
// Functional notes
// [RULE1] Mode 00 is an 8-bit count behind a 5-bit prescaler; 01 is 16-bit.
// [RULE2] Mode 10 counts the low byte and reloads it from the high byte.
// [RULE3] Mode 11 splits timer 0 into separate low and high 8-bit counters.
// [RULE4] Mode 11 halts timer 1 with its count kept as it is.
// [RULE5] Mode register: timer 0 in bits 3:0, timer 1 in bits 7:4.
// [RULE6] Source bit 0 counts the divided clock, 1 counts the count pin.
// [RULE7] Gate 0 counts on run bit alone; gate 1 also needs the pin high.
// [RULE8] Interrupt pin 0 gates timer 0, interrupt pin 1 gates timer 1.
// [RULE9] Count pin 0 clocks timer 0, count pin 1 clocks timer 1.
// [RULE10] A timer counts only while its run-control bit is one; in mode 11 the timer 0 high byte counts on timer 1's run bit.
// [RULE11] A carry sets the overflow flag; servicing clears it again.
// [RULE12] Count pins are synchronised; each falling edge counts once.
//
// The APB register port is this design's own decision.
`timescale 1ns/10ps
`include "timer_cfg.svh"
module dual_timer #(
   parameter int TICK_DIV = `TMR_TICK_DIV
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`TMR_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // External pins
   input wire logic count_pin_0,
   input wire logic count_pin_1,
   input wire logic ext_interrupt_pin_0,
   input wire logic ext_interrupt_pin_1,
   // Interrupt service acknowledge, one per timer
   input wire logic svc_ack_0,
   input wire logic svc_ack_1,
   // Flags and interrupt
   output logic overflow_flag_0,
   output logic overflow_flag_1,
   output logic irq
);
   import timer_pkg::*;

   // Pin order: count 0, count 1, gate 0, gate 1
   logic [3:0] pin_raw;
   logic [3:0] pin_s1_q;
   logic [3:0] pin_s2_q;
   logic [1:0] cnt_prev_q;
   logic [1:0] ext_fall;

   logic [7:0] tick_cnt_q;
   logic tick_q;

   logic [7:0] mode_q;
   logic run0_q;
   logic run1_q;
   logic [1:0] stat_q;
   logic [1:0] stat_d;
   logic [1:0] mask_q;
   logic irq_q;

   timer_cfg_s cfg0;
   timer_cfg_s cfg1;
   byte_wr_s wr0;
   byte_wr_s wr1;
   logic [7:0] tl0;
   logic [7:0] th0;
   logic [7:0] tl1;
   logic [7:0] th1;
   logic ovf0_main;
   logic ovf0_aux;
   logic ovf1_main;
   logic ovf1_aux;

   logic access;
   logic commit;
   logic wr_en;
   logic addr_ok;
   logic [7:0] idx;
   logic mapped;
   logic [31:0] rd_word;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;

   assign pin_raw = {ext_interrupt_pin_1, ext_interrupt_pin_0,
                     count_pin_1, count_pin_0};

   // Two stages per pin; only the second stage feeds logic
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_q <= 4'h0;
         pin_s2_q <= 4'h0;
      end else begin
         pin_s1_q <= pin_raw;
         pin_s2_q <= pin_s1_q;
      end
   end

   // [RULE12] falling edge detect
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt_prev_q <= 2'h0;
      end else begin
         cnt_prev_q <= pin_s2_q[1:0];
      end
   end

   // [RULE9] per-timer count pin
   assign ext_fall = cnt_prev_q & ~pin_s2_q[1:0];

   // Divided oscillator tick, one cycle wide
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt_q <= `TMR_BYTE_RST;
         tick_q <= 1'b0;
      end else if (tick_cnt_q == 8'(TICK_DIV - 1)) begin
         tick_cnt_q <= `TMR_BYTE_RST;
         tick_q <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + `TMR_BYTE_ONE;
         tick_q <= 1'b0;
      end
   end

   // APB decode; aligned words, index times four
   assign idx = paddr[9:2];
   assign addr_ok = (paddr[`TMR_ADDR_W-1:10] == 2'h0) && (paddr[1:0] == 2'h0);
   assign access = psel & penable;
   // Write lands on the edge where the master sees pready
   assign commit = access & pready_q;
   assign wr_en = commit & pwrite & ~pslverr_q;

   always_comb begin
      mapped = addr_ok;
      rd_word = `TMR_WORD_RST;
      unique case (idx)
         `TMR_IDX_RUN: begin
            rd_word[`TMR_RUN0_BIT] = run0_q;
            rd_word[`TMR_FLAG0_BIT] = stat_q[`TMR_ST_OVF0];
            rd_word[`TMR_RUN1_BIT] = run1_q;
            rd_word[`TMR_FLAG1_BIT] = stat_q[`TMR_ST_OVF1];
         end
         `TMR_IDX_MODE: begin
            rd_word[7:0] = mode_q;
         end
         `TMR_IDX_TL0: begin
            rd_word[7:0] = tl0;
         end
         `TMR_IDX_TL1: begin
            rd_word[7:0] = tl1;
         end
         `TMR_IDX_TH0: begin
            rd_word[7:0] = th0;
         end
         `TMR_IDX_TH1: begin
            rd_word[7:0] = th1;
         end
         `TMR_IDX_STAT: begin
            rd_word[1:0] = stat_q;
         end
         `TMR_IDX_MASK: begin
            rd_word[1:0] = mask_q;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   // One wait state, then answer for one cycle
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= `TMR_WORD_RST;
      end else if (access & ~pready_q) begin
         pready_q <= 1'b1;
         pslverr_q <= ~mapped;
         prdata_q <= (mapped & ~pwrite) ? rd_word : `TMR_WORD_RST;
      end else begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end
   end

   // [RULE5] mode register nibbles
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= `TMR_BYTE_RST;
      end else if (wr_en && idx == `TMR_IDX_MODE) begin
         mode_q <= pwdata[7:0];
      end
   end

   assign cfg0 = mode_q[`TMR_CFG0_LSB +: 4];
   assign cfg1 = mode_q[`TMR_CFG1_LSB +: 4];

   // [RULE10] run-control bits
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         run0_q <= 1'b0;
         run1_q <= 1'b0;
      end else if (wr_en && idx == `TMR_IDX_RUN) begin
         run0_q <= pwdata[`TMR_RUN0_BIT];
         run1_q <= pwdata[`TMR_RUN1_BIT];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mask_q <= 2'h0;
      end else if (wr_en && idx == `TMR_IDX_MASK) begin
         mask_q <= pwdata[1:0];
      end
   end

   always_comb begin
      wr0.wr_lo = wr_en && idx == `TMR_IDX_TL0;
      wr0.wr_hi = wr_en && idx == `TMR_IDX_TH0;
      wr0.data = pwdata[7:0];
      wr1.wr_lo = wr_en && idx == `TMR_IDX_TL1;
      wr1.wr_hi = wr_en && idx == `TMR_IDX_TH1;
      wr1.data = pwdata[7:0];
   end

   // [RULE8] interrupt pin 0 gates timer 0
   timer_unit #(
      .SPLIT_OK(1'b1)
   ) u_timer0 (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .cfg(cfg0),
      .run(run0_q),
      .run_aux(run1_q),
      .gate_pin(pin_s2_q[2]),
      .tick(tick_q),
      .ext_fall(ext_fall[0]),
      .wr(wr0),
      .low_q(tl0),
      .high_q(th0),
      .ovf_main(ovf0_main),
      .ovf_aux(ovf0_aux)
   );

   // [RULE4] no split, so mode 11 holds
   timer_unit #(
      .SPLIT_OK(1'b0)
   ) u_timer1 (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .cfg(cfg1),
      .run(run1_q),
      .run_aux(1'b0),
      .gate_pin(pin_s2_q[3]),
      .tick(tick_q),
      .ext_fall(ext_fall[1]),
      .wr(wr1),
      .low_q(tl1),
      .high_q(th1),
      .ovf_main(ovf1_main),
      .ovf_aux(ovf1_aux)
   );

   // [RULE11] set beats ack and write-one clear
   always_comb begin
      stat_d = stat_q;
      if (svc_ack_0) begin
         stat_d[`TMR_ST_OVF0] = 1'b0;
      end
      if (svc_ack_1) begin
         stat_d[`TMR_ST_OVF1] = 1'b0;
      end
      if (wr_en && idx == `TMR_IDX_STAT) begin
         stat_d = stat_d & ~pwdata[1:0];
      end
      if (ovf0_main) begin
         stat_d[`TMR_ST_OVF0] = 1'b1;
      end
      // Split high byte borrows timer 1's flag
      if (ovf1_main | ovf1_aux | ovf0_aux) begin
         stat_d[`TMR_ST_OVF1] = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         stat_q <= 2'h0;
      end else begin
         stat_q <= stat_d;
      end
   end

   // Registered so the pin never glitches
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(stat_d & mask_q);
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign overflow_flag_0 = stat_q[`TMR_ST_OVF0];
   assign overflow_flag_1 = stat_q[`TMR_ST_OVF1];
   assign irq = irq_q;
endmodule

// ### dual_timer_monitor.sv
// Port assertions for the dual timer block
`timescale 1ns/10ps
module dual_timer_monitor (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Service and flags
   input wire logic svc_ack_0,
   input wire logic svc_ack_1,
   input wire logic overflow_flag_0,
   input wire logic overflow_flag_1,
   input wire logic irq
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held past one cycle");
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("pready outside an access phase");
   a_access_answer: assert property (psel && penable && !pready |=> pready)
      else $error("access phase not answered in time");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_err_data: assert property (pslverr |-> prdata == 32'h0000_0000)
      else $error("refused access returned data");
   a_read_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   a_reset_quiet: assert property ($rose(rst_n) |->
      !pready && !irq && !overflow_flag_0 && !overflow_flag_1)
      else $error("outputs active after reset");
   // Holds only while no wrap meets the acknowledge
   a_ack_clears: assert property (svc_ack_0 && overflow_flag_0 |=>
      !overflow_flag_0) else $error("flag0 not cleared by service");
   a_flag_sticky: assert property (overflow_flag_1 && !svc_ack_1 &&
      !(psel && pwrite) |=> overflow_flag_1) else $error("flag1 dropped");
endmodule
bind dual_timer dual_timer_monitor dual_timer_monitor_i (
   .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .svc_ack_0(svc_ack_0), .svc_ack_1(svc_ack_1),
   .overflow_flag_0(overflow_flag_0), .overflow_flag_1(overflow_flag_1),
   .irq(irq));

// ### pin_driver.sv
// Model of the external count and gate pins
`timescale 1ns/10ps
module pin_driver (
   // Clock
   input wire logic clk_sys,
   // Pins
   output logic count_pin_0,
   output logic count_pin_1,
   output logic ext_interrupt_pin_0,
   output logic ext_interrupt_pin_1
);
   // Count pins idle high, as pulled-up port pins do
   initial begin
      count_pin_0 = 1'h1;
      count_pin_1 = 1'h1;
      ext_interrupt_pin_0 = 1'h0;
      ext_interrupt_pin_1 = 1'h0;
   end
   task automatic pulse(input bit pin, input int n);
      repeat (n) begin
         @(posedge clk_sys);
         if (pin) count_pin_1 <= 1'h0; else count_pin_0 <= 1'h0;
         repeat (3) @(posedge clk_sys);
         if (pin) count_pin_1 <= 1'h1; else count_pin_0 <= 1'h1;
         repeat (2) @(posedge clk_sys);
      end
      // Room for the synchroniser delay
      repeat (6) @(posedge clk_sys);
   endtask
   task automatic gate(input bit pin, input logic v);
      @(posedge clk_sys);
      if (pin) ext_interrupt_pin_1 <= v; else ext_interrupt_pin_0 <= v;
   endtask
endmodule

// ### tb_dual_timer.sv
// Self-checking bench for the dual timer block
`timescale 1ns/10ps
`include "timer_cfg.svh"
module tb_dual_timer;
   logic clk_sys = 1'h0;
   logic rst_n = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [`TMR_ADDR_W-1:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic svc_ack_0 = 1'h0;
   logic svc_ack_1 = 1'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic cnt0;
   logic cnt1;
   logic gate0;
   logic gate1;
   logic flag0;
   logic flag1;
   logic irq;
   logic [31:0] rd;
   logic err;
   int miscompares = 0;
   int n_checks = 0;
   // Short tick divide keeps the wraps quick
   dual_timer #(.TICK_DIV(2)) dual_timer_i (
      .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .count_pin_0(cnt0),
      .count_pin_1(cnt1), .ext_interrupt_pin_0(gate0),
      .ext_interrupt_pin_1(gate1), .svc_ack_0(svc_ack_0),
      .svc_ack_1(svc_ack_1), .overflow_flag_0(flag0),
      .overflow_flag_1(flag1), .irq(irq));
   pin_driver pin_driver_i (.clk_sys(clk_sys), .count_pin_0(cnt0),
      .count_pin_1(cnt1), .ext_interrupt_pin_0(gate0),
      .ext_interrupt_pin_1(gate1));
   initial begin
      forever #2 clk_sys = ~clk_sys;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string what);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got,
            exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] idx,
      input logic [7:0] wd);
      @(posedge clk_sys);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= {24'h00_0000, wd};
      @(posedge clk_sys);
      penable <= 1'h1;
      // Only the watchdog ends a wait for pready
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic rchk(input logic [7:0] idx, input logic [7:0] exp,
      input string what);
      apb(1'h0, idx, 8'h00);
      chk(rd, {24'h00_0000, exp}, what);
   endtask
   task automatic wait_flag(input bit t1);
      int n;
      n = 0;
      while ((t1 ? flag1 : flag0) !== 1'h1 && n < 3000) begin
         @(posedge clk_sys);
         n++;
      end
   endtask
   task automatic t_reset_regs;
      rchk(`TMR_IDX_MODE, 8'h00, "mode reset");
      rchk(`TMR_IDX_TL0, 8'h00, "low0 reset");
      apb(1'h1, `TMR_IDX_MODE, 8'hA5);
      rchk(`TMR_IDX_MODE, 8'hA5, "mode rw");
      apb(1'h0, 8'h95, 8'h00);
      chk({31'h0, err}, 32'h1, "unmapped error");
   endtask
   task automatic t_wrap16;
      apb(1'h1, `TMR_IDX_MASK, 8'h01);
      apb(1'h1, `TMR_IDX_MODE, 8'h01);
      apb(1'h1, `TMR_IDX_TL0, 8'hFE);
      apb(1'h1, `TMR_IDX_TH0, 8'hFF);
      apb(1'h1, `TMR_IDX_RUN, 8'h10);
      wait_flag(1'h0);
      chk({31'h0, flag0}, 32'h1, "flag0 on wrap");
      apb(1'h1, `TMR_IDX_RUN, 8'h00);
      chk({31'h0, irq}, 32'h1, "irq unmasked");
      rchk(`TMR_IDX_TH0, 8'h00, "carry to high");
      apb(1'h1, `TMR_IDX_TL0, 8'h5A);
      repeat (10) @(posedge clk_sys);
      rchk(`TMR_IDX_TL0, 8'h5A, "stopped count");
      apb(1'h1, `TMR_IDX_STAT, 8'h01);
      // Flags update on the edge that ends the write
      @(posedge clk_sys);
      chk({30'h0, irq, flag0}, 32'h0, "status cleared");
      // Second wrap, cleared by the service acknowledge
      apb(1'h1, `TMR_IDX_TL0, 8'hFF);
      apb(1'h1, `TMR_IDX_TH0, 8'hFF);
      apb(1'h1, `TMR_IDX_RUN, 8'h10);
      wait_flag(1'h0);
      svc_ack_0 <= 1'h1;
      @(posedge clk_sys);
      svc_ack_0 <= 1'h0;
      @(posedge clk_sys);
      chk({31'h0, flag0}, 32'h0, "serviced0");
      apb(1'h1, `TMR_IDX_RUN, 8'h00);
   endtask
   task automatic t_reload1;
      apb(1'h1, `TMR_IDX_MODE, 8'h20);
      apb(1'h1, `TMR_IDX_TH1, 8'hF0);
      apb(1'h1, `TMR_IDX_TL1, 8'hFD);
      apb(1'h1, `TMR_IDX_RUN, 8'h40);
      wait_flag(1'h1);
      apb(1'h1, `TMR_IDX_RUN, 8'h00);
      chk({30'h0, irq, flag1}, 32'h1, "flag1 masked");
      rchk(`TMR_IDX_TH1, 8'hF0, "reload kept");
      apb(1'h0, `TMR_IDX_TL1, 8'h00);
      chk(rd & 32'hF0, 32'hF0, "reloaded low");
      @(posedge clk_sys);
      svc_ack_1 <= 1'h1;
      @(posedge clk_sys);
      svc_ack_1 <= 1'h0;
      @(posedge clk_sys);
      chk({31'h0, flag1}, 32'h0, "serviced");
      apb(1'h1, `TMR_IDX_STAT, 8'h02);
   endtask
   task automatic t_halt1;
      apb(1'h1, `TMR_IDX_MODE, 8'h30);
      apb(1'h1, `TMR_IDX_TL1, 8'h55);
      apb(1'h1, `TMR_IDX_RUN, 8'h40);
      repeat (40) @(posedge clk_sys);
      rchk(`TMR_IDX_TL1, 8'h55, "halted");
      apb(1'h1, `TMR_IDX_RUN, 8'h00);
   endtask
   task automatic t_ext_pre;
      apb(1'h1, `TMR_IDX_MODE, 8'h0C);
      apb(1'h1, `TMR_IDX_TL0, 8'hFE);
      apb(1'h1, `TMR_IDX_TH0, 8'h00);
      apb(1'h1, `TMR_IDX_RUN, 8'h10);
      pin_driver_i.gate(1'h1, 1'h1);
      pin_driver_i.pulse(1'h0, 2);
      rchk(`TMR_IDX_TL0, 8'hFE, "gated off");
      pin_driver_i.gate(1'h0, 1'h1);
      pin_driver_i.pulse(1'h1, 2);
      rchk(`TMR_IDX_TL0, 8'hFE, "other pin");
      pin_driver_i.pulse(1'h0, 1);
      rchk(`TMR_IDX_TL0, 8'hFF, "one edge");
      pin_driver_i.pulse(1'h0, 1);
      rchk(`TMR_IDX_TL0, 8'hE0, "prescale wrap");
      rchk(`TMR_IDX_TH0, 8'h01, "prescale carry");
   endtask
   task automatic t_split0;
      apb(1'h1, `TMR_IDX_MODE, 8'h07);
      apb(1'h1, `TMR_IDX_TL0, 8'h00);
      apb(1'h1, `TMR_IDX_TH0, 8'h00);
      pin_driver_i.pulse(1'h0, 2);
      rchk(`TMR_IDX_TH0, 8'h00, "split high idle");
      rchk(`TMR_IDX_TL0, 8'h02, "split low");
      apb(1'h1, `TMR_IDX_RUN, 8'h40);
      repeat (20) @(posedge clk_sys);
      apb(1'h1, `TMR_IDX_RUN, 8'h00);
      apb(1'h0, `TMR_IDX_TH0, 8'h00);
      chk({31'h0, rd[7:0] != 8'h00}, 32'h1, "split high runs");
      rchk(`TMR_IDX_TL0, 8'h02, "split low kept");
   endtask
   task automatic end_of_test;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys);
      miscompares++;
      end_of_test;
   end
   initial begin
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'h1;
      t_reset_regs;
      t_wrap16;
      t_reload1;
      t_halt1;
      t_ext_pre;
      t_split0;
      end_of_test;
   end
endmodule
